//--- hdl/iord_pkg.sv
package iord_pkg;

  // Register byte addresses on the AXI4-Lite slave
  localparam logic [7:0] CtlAddr0   = 8'h00;
  localparam logic [7:0] BaseAddr0  = 8'h04;
  localparam logic [7:0] CtlAddr1   = 8'h08;
  localparam logic [7:0] BaseAddr1  = 8'h0c;
  localparam logic [7:0] StatusAddr = 8'h10;

  // Reset values
  localparam logic [7:0] CtlReset  = 8'h00;
  localparam logic [7:0] BaseReset = 8'h00;

  // Control register fields
  localparam int CtlMaskLo   = 0;
  localparam int CtlMaskHi   = 4;
  localparam int CtlLatchBit = 5;
  localparam int CtlSlotBit  = 6;
  localparam int CtlWideBit  = 7;

  // Device register window inside the slot space (low 12 address bits)
  localparam logic [11:0] OwnRegLo = 12'hc80;
  localparam logic [11:0] OwnRegHi = 12'hcaf;

  // AXI response codes
  localparam logic [1:0] RespOkay   = 2'h0;
  localparam logic [1:0] RespSlvErr = 2'h2;

  // Programmed settings of one range
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] base;
  } iord_range_s;

endpackage

//--- hdl/iord_io_range_decoder.sv
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Operation
// - Two ranges, each with select output
// - Decode only while address enable low
// - Drive 32-bit indication on wide hits
// - No other bus control driven
// - Bit 5 picks strobe-latched or combinational
// - Data enables stay off outside registers
// - Control bits 4:0 mask base compare
// - No mask bits gives one doubleword
// - Base bits 5:0 map to address 7:2, bits 7:6 to address 9:8
// - Bit 6 selects slot-specific decode
// - General decode off when base 7:6 zero
// - Address 1:0 ignored; byte-enable parity gates data enable
// - Slot decode needs address 9:8 zero
// - Own registers at 0C80h to 0CAFh
module iord_io_range_decoder (
  // Clock, enable and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  // AXI4-Lite register slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Expansion bus pins (asynchronous, synchronised here except the byte enables)
  input  wire logic [15:0] latched_bus_address,
  input  wire logic [3:0]  latched_byte_enables_n,
  input  wire logic        addrEnable,
  input  wire logic        cmdStrobe_n,
  input  wire logic        ioRead_n,
  // Expansion bus and board outputs
  output logic [1:0]       range_select_n,
  output logic             ex32_n,
  output logic             ex32Oe,
  output logic             internal_data_out_enable
);

  // Input synchronisers: first stage read only by second stage
  logic [15:0] adrMeta_q; // Address, first stage
  logic [15:0] adr_q;     // Address, settled
  logic        aenMeta_q; // Address enable, first stage
  logic        aen_q;     // Address enable, settled
  logic        cmdMeta_q; // Command strobe, first stage
  logic        cmd_q;     // Command strobe, settled
  logic        rdMeta_q;  // Read strobe, first stage
  logic        rd_q;      // Read strobe, settled

  // Address pins; a torn word only lasts while the pins move
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      adrMeta_q <= 16'h0000;
      adr_q     <= 16'h0000;
    end else if (clkEn) begin
      adrMeta_q <= latched_bus_address;
      adr_q     <= adrMeta_q;
    end
  end

  // Strobe pins, idle high out of reset so no false edge follows
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      aenMeta_q <= 1'b1;
      aen_q     <= 1'b1;
      cmdMeta_q <= 1'b1;
      cmd_q     <= 1'b1;
      rdMeta_q  <= 1'b1;
      rd_q      <= 1'b1;
    end else if (clkEn) begin
      aenMeta_q <= addrEnable;
      aen_q     <= aenMeta_q;
      cmdMeta_q <= cmdStrobe_n;
      cmd_q     <= cmdMeta_q;
      rdMeta_q  <= ioRead_n;
      rd_q      <= rdMeta_q;
    end
  end

  // Byte enables play no part in the range decode; their parity gates the data enable
  logic unusedBe;
  assign unusedBe = ^latched_byte_enables_n;

  // Register file
  iord_pkg::iord_range_s range_q [2];
  logic [7:0] rawCtl [2];
  logic [7:0] rawBase [2];

  // AXI write channel state
  logic       awHeld_q, wHeld_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic       bValid_q;
  logic [1:0] bResp_q;
  logic       awRdy_q;  // Address channel open
  logic       wRdy_q;   // Data channel open

  logic awTake;
  logic wTake;
  logic doWrite;
  logic wrMapped;
  assign awTake  = s_axi_awvalid && awRdy_q;
  assign wTake   = s_axi_wvalid && wRdy_q;
  assign doWrite = awHeld_q && wHeld_q && !bValid_q;
  assign wrMapped = (awAddr_q == iord_pkg::CtlAddr0)
                 || (awAddr_q == iord_pkg::BaseAddr0)
                 || (awAddr_q == iord_pkg::CtlAddr1)
                 || (awAddr_q == iord_pkg::BaseAddr1);

  // Accept address and data in either order, answer after both
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q  <= 32'h00000000;
      wStrb_q  <= 4'h0;
      bValid_q <= 1'b0;
      bResp_q  <= iord_pkg::RespOkay;
      awRdy_q  <= 1'b1;
      wRdy_q   <= 1'b1;
    end else if (clkEn) begin
      if (awTake) begin
        awHeld_q <= 1'b1;
        awRdy_q  <= 1'b0;
        awAddr_q <= s_axi_awaddr;
      end
      if (wTake) begin
        wHeld_q <= 1'b1;
        wRdy_q  <= 1'b0;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bValid_q <= 1'b1;
        bResp_q  <= wrMapped ? iord_pkg::RespOkay : iord_pkg::RespSlvErr;
      end else if (bValid_q && s_axi_bready) begin
        bValid_q <= 1'b0;
        awRdy_q  <= 1'b1;
        wRdy_q   <= 1'b1;
      end
    end
  end

  // Range registers, low byte lane only
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gRange
      logic [7:0] ctlAddr, baseAddr;
      assign ctlAddr  = gi ? iord_pkg::CtlAddr1 : iord_pkg::CtlAddr0;
      assign baseAddr = gi ? iord_pkg::BaseAddr1 : iord_pkg::BaseAddr0;
      assign rawCtl[gi]  = range_q[gi].ctl;
      assign rawBase[gi] = range_q[gi].base;
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          range_q[gi].ctl  <= iord_pkg::CtlReset;
          range_q[gi].base <= iord_pkg::BaseReset;
        end else if (clkEn && doWrite && wStrb_q[0]) begin
          if (awAddr_q == ctlAddr)
            range_q[gi].ctl <= wData_q[7:0];
          if (awAddr_q == baseAddr)
            range_q[gi].base <= wData_q[7:0];
        end
      end
    end
  endgenerate

  // Read channel
  logic        rValid_q;
  logic        arRdy_q;  // Read address channel open
  logic [31:0] rData_q;
  logic [1:0]  rResp_q;
  logic        arTake, rdMapped;
  logic        isCtl0, isBase0, isCtl1, isBase1, isStat;
  logic [31:0] rdWord;
  logic [1:0]  selState;
  assign arTake = s_axi_arvalid && arRdy_q;
  // One strobe per readable word
  assign isCtl0  = s_axi_araddr == iord_pkg::CtlAddr0;
  assign isBase0 = s_axi_araddr == iord_pkg::BaseAddr0;
  assign isCtl1  = s_axi_araddr == iord_pkg::CtlAddr1;
  assign isBase1 = s_axi_araddr == iord_pkg::BaseAddr1;
  assign isStat  = s_axi_araddr == iord_pkg::StatusAddr;
  assign rdMapped = isCtl0 || isBase0 || isCtl1 || isBase1 || isStat;
  // Status shows live wide flag, data enable and selects
  assign rdWord =
    isCtl0  ? {24'h000000, rawCtl[0]}  :
    isBase0 ? {24'h000000, rawBase[0]} :
    isCtl1  ? {24'h000000, rawCtl[1]}  :
    isBase1 ? {24'h000000, rawBase[1]} :
    isStat  ? {28'h0000000, !ex32_n, internal_data_out_enable, selState} :
    32'h00000000;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rValid_q <= 1'b0;
      rData_q  <= 32'h00000000;
      rResp_q  <= iord_pkg::RespOkay;
      arRdy_q  <= 1'b1;
    end else if (clkEn) begin
      if (arTake) begin
        rValid_q <= 1'b1;
        arRdy_q  <= 1'b0;
        rData_q  <= rdWord;
        rResp_q  <= rdMapped ? iord_pkg::RespOkay : iord_pkg::RespSlvErr;
      end else if (rValid_q && s_axi_rready) begin
        rValid_q <= 1'b0;
        arRdy_q  <= 1'b1;
      end
    end
  end

  // Bus outputs, all straight from registers
  assign s_axi_awready = awRdy_q;
  assign s_axi_wready  = wRdy_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_arready = arRdy_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;

  // Address decode per range
  logic [1:0] hit;
  logic [1:0] latchMode;
  logic [1:0] wide;
  logic       busOk;
  assign busOk = !aen_q;

  generate
    for (gi = 0; gi < 2; gi++) begin : gDec
      logic [5:0] mask, cmp;
      logic       slot, enGen;
      // Set mask bits drop base bits from the compare
      assign mask = {{2{rawCtl[gi][iord_pkg::CtlMaskHi]}},
                     rawCtl[gi][3:iord_pkg::CtlMaskLo]};
      // Base 5:4 against address 7:6, base 3:0 against 5:2
      assign cmp = (rawBase[gi][5:0] ^ adr_q[7:2]) & ~mask;
      assign slot = rawCtl[gi][iord_pkg::CtlSlotBit];
      assign enGen = |rawBase[gi][7:6];
      // Slot mode: address 9:8 zero, slot nibble left to qualification
      assign hit[gi] = busOk && (cmp == 6'h00) &&
        (slot ? (adr_q[9:8] == 2'h0)
              : (enGen && adr_q[9:8] == rawBase[gi][7:6]));
      assign latchMode[gi] = rawCtl[gi][iord_pkg::CtlLatchBit];
      assign wide[gi] = rawCtl[gi][iord_pkg::CtlWideBit];
    end
  endgenerate

  // Select outputs, latched across the command strobe when asked
  logic [1:0] sel_q, held_q;
  logic       cmdFall;
  logic       cmdPrev_q;
  assign cmdFall = cmdPrev_q && !cmd_q;

  generate
    for (gi = 0; gi < 2; gi++) begin : gSel
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          held_q[gi] <= 1'b0;
          sel_q[gi]  <= 1'b0;
        end else if (clkEn) begin
          if (cmd_q)
            held_q[gi] <= 1'b0;
          else if (cmdFall)
            held_q[gi] <= hit[gi];
          sel_q[gi] <= latchMode[gi] ?
            (cmdFall ? hit[gi] : (held_q[gi] && !cmd_q))
            : hit[gi];
        end
      end
    end
  endgenerate
  assign selState = sel_q;

  // Own register window decode and output stage
  logic ownSpace, anySel, anyWide;
  assign ownSpace = busOk && (adr_q[9:8] == 2'h0) &&
    (adr_q[11:0] >= iord_pkg::OwnRegLo) &&
    (adr_q[11:0] <= iord_pkg::OwnRegHi);
  assign anySel  = |sel_q;
  assign anyWide = |(sel_q & wide);

  logic [1:0] selN_q;
  logic       ex32n_q, ex32oe_q, internal_data_out_enable_q;

  // Previous strobe level for the falling-edge detect
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      cmdPrev_q <= 1'b1;
    else if (clkEn)
      cmdPrev_q <= cmd_q;
  end

  // Active-low selects, all released in reset
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      selN_q <= 2'h3;
    else if (clkEn)
      selN_q <= ~sel_q;
  end

  // Width answer, driven only while a range is selected
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ex32n_q  <= 1'b1;
      ex32oe_q <= 1'b0;
    end else if (clkEn) begin
      ex32n_q  <= !anyWide;
      ex32oe_q <= anySel;
    end
  end

  // Data enables only for reads of the own window
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      internal_data_out_enable_q <= 1'b0;
    else if (clkEn)
      internal_data_out_enable_q <= ownSpace && !rd_q && !cmd_q && !unusedBe;
  end

  // Pins, each from its own register
  assign range_select_n           = selN_q;
  assign ex32_n                   = ex32n_q;
  assign ex32Oe                   = ex32oe_q;
  assign internal_data_out_enable = internal_data_out_enable_q;

endmodule

//--- tb/iord_properties.sv
`timescale 1ns/1ps
// Port checks of the range decoder
module iord_properties (
  // Clock and reset
  input wire logic        clock,
  input wire logic        sys_rst,
  // Expansion bus
  input wire logic [15:0] latched_bus_address,
  input wire logic        addrEnable,
  input wire logic        cmdStrobe_n,
  input wire logic [1:0]  range_select_n,
  input wire logic        ex32_n,
  input wire logic        ex32Oe,
  input wire logic        internal_data_out_enable,
  // Register bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Address outside the own register window
  wire logic outWin = latched_bus_address[11:0] < iord_pkg::OwnRegLo ||
                      latched_bus_address[11:0] > iord_pkg::OwnRegHi;
  // Both halves of a write taken at one edge
  sequence wrTake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  aen_block_a: assert property (
    (addrEnable && cmdStrobe_n) [*5] |-> range_select_n == 2'h3)
    else $error("select without address enable");
  ex32_only_a: assert property (
    ex32Oe == (range_select_n != 2'h3))
    else $error("wide flag driven outside a select");
  ex32_drive_a: assert property (
    !ex32_n |-> ex32Oe)
    else $error("wide flag low while undriven");
  internal_data_out_enable_gate_a: assert property (
    outWin [*6] |-> !internal_data_out_enable)
    else $error("data enable outside register window");
  wr_answer_a: assert property (wrTake |-> ##2 s_axi_bvalid)
    else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped");
endmodule

bind iord_io_range_decoder iord_properties u_iord_properties (
  .clock, .sys_rst, .latched_bus_address, .addrEnable, .cmdStrobe_n,
  .range_select_n, .ex32_n, .ex32Oe, .internal_data_out_enable,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready);

//--- tb/iord_bus_host.sv
`timescale 1ns/1ps
// Host side of the expansion bus, drives the decode pins
module iord_bus_host (
  // Clock
  input wire logic    clock,
  // Bus pins
  output logic [15:0] latched_bus_address,
  output logic [3:0]  latched_byte_enables_n,
  output logic        addrEnable,
  output logic        cmdStrobe_n,
  output logic        ioRead_n
);
  // Idle bus: no enable, no command
  initial begin
    latched_bus_address = 16'h0;
    latched_byte_enables_n = 4'hf;
    addrEnable = 1'b1;
    cmdStrobe_n = 1'b1;
    ioRead_n = 1'b1;
  end
  // One bus step; enable low whenever an answer is wanted
  task automatic put(input logic [15:0] a, input logic aen, cmd);
    @(posedge clock);
    latched_bus_address <= a;
    latched_byte_enables_n <= 4'h0;
    addrEnable <= aen;
    cmdStrobe_n <= cmd;
    ioRead_n <= cmd;
  endtask
endmodule

//--- tb/test_iord_io_range_decoder.sv
`timescale 1ns/1ps
// Register and decode tests of the range decoder
module test_iord_io_range_decoder;
  localparam logic [1:0] Ok = iord_pkg::RespOkay;
  // Design signals
  logic        clock, sys_rst, ex32_n, ex32Oe, internal_data_out_enable;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, addrEnable, cmdStrobe_n;
  logic        ioRead_n, clkEn;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp, range_select_n;
  logic [15:0] latched_bus_address;
  logic [3:0]  latched_byte_enables_n;
  int          mismatches, n_tests;
  // Decoder and bus host
  iord_io_range_decoder u_iord_io_range_decoder (
    .clock, .sys_rst, .clkEn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .latched_bus_address,
    .latched_byte_enables_n, .addrEnable, .cmdStrobe_n, .ioRead_n,
    .range_select_n, .ex32_n, .ex32Oe, .internal_data_out_enable);
  iord_bus_host u_iord_bus_host (
    .clock, .latched_bus_address, .latched_byte_enables_n, .addrEnable,
    .cmdStrobe_n, .ioRead_n);
  // Clock source
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Value comparison
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Register write; waits for the response, then checks it
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    logic awDone, wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clock);
      if (!awDone && s_axi_awready) begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wDone && s_axi_wready) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge clock);
    s_axi_bready <= 1'b0;
    chk("write resp", {30'h0, r}, {30'h0, s_axi_bresp});
  endtask
  // Register read with data and response checks
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("read data", d, s_axi_rdata);
    chk("read resp", {30'h0, r}, {30'h0, s_axi_rresp});
  endtask
  // Let the pin pipeline settle, then compare decode outputs
  task automatic look(input logic [1:0] s, input logic w, de);
    repeat (6) @(posedge clock);
    chk("select", {30'h0, s}, {30'h0, range_select_n});
    chk("wide", {31'h0, w}, {31'h0, ex32_n});
    chk("data enable", {31'h0, de}, {31'h0, internal_data_out_enable});
  endtask
  // Address with strobe high first, then the command step
  task automatic probe(input logic [15:0] a, input logic aen, cmd,
                       input logic [1:0] s, input logic w, de);
    u_iord_bus_host.put(a, aen, 1'b1);
    repeat (6) @(posedge clock);
    u_iord_bus_host.put(a, aen, cmd);
    look(s, w, de);
  endtask
  // Verdict and end of run
  task automatic close_out;
    $display("counts %0d checks %0d mismatches", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #100us;
    mismatches++;
    close_out;
  end
  // Reset, then the tests
  initial begin
    {sys_rst, mismatches, n_tests} = {1'b1, 64'h0};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {clkEn, s_axi_wstrb} = 5'h1f;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 4; i++)
      axi_rd(8'(4 * i), 32'h0, Ok);
    axi_wr(8'h14, 32'h5a, iord_pkg::RespSlvErr);
    axi_rd(8'h14, 32'h0, iord_pkg::RespSlvErr);
    axi_wr(iord_pkg::CtlAddr0, 32'hef, Ok);
    axi_wr(iord_pkg::BaseAddr0, 32'h20, Ok);
    axi_wr(iord_pkg::CtlAddr1, 32'h00, Ok);
    axi_wr(iord_pkg::BaseAddr1, 32'h4b, Ok);
    axi_rd(iord_pkg::CtlAddr0, 32'hef, Ok);
    s_axi_wstrb <= 4'he;
    axi_wr(iord_pkg::CtlAddr0, 32'h00, Ok);
    s_axi_wstrb <= 4'hf;
    axi_rd(iord_pkg::CtlAddr0, 32'hef, Ok);
    $display("test registers done");
    probe(16'h5080, 1'b0, 1'b1, 2'h3, 1'b1, 1'b0);
    probe(16'h5080, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0);
    u_iord_bus_host.put(16'h5180, 1'b0, 1'b0);
    look(2'h2, 1'b0, 1'b0);
    u_iord_bus_host.put(16'h5180, 1'b0, 1'b1);
    look(2'h3, 1'b1, 1'b0);
    probe(16'h70bf, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0);
    probe(16'h50c0, 1'b0, 1'b0, 2'h3, 1'b1, 1'b0);
    probe(16'h5180, 1'b0, 1'b0, 2'h3, 1'b1, 1'b0);
    probe(16'h5c80, 1'b0, 1'b0, 2'h2, 1'b0, 1'b1);
    axi_rd(iord_pkg::StatusAddr, 32'hd, Ok);
    probe(16'h5cb0, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0);
    probe(16'h012c, 1'b0, 1'b1, 2'h1, 1'b1, 1'b0);
    probe(16'h0130, 1'b0, 1'b1, 2'h3, 1'b1, 1'b0);
    probe(16'h012c, 1'b1, 1'b1, 2'h3, 1'b1, 1'b0);
    axi_wr(iord_pkg::CtlAddr1, 32'h10, Ok);
    probe(16'h01ec, 1'b0, 1'b1, 2'h1, 1'b1, 1'b0);
    clkEn <= 1'b0;
    u_iord_bus_host.put(16'h0130, 1'b0, 1'b1);
    look(2'h1, 1'b1, 1'b0);
    clkEn <= 1'b1;
    look(2'h3, 1'b1, 1'b0);
    axi_wr(iord_pkg::BaseAddr1, 32'h0b, Ok);
    probe(16'h002c, 1'b0, 1'b1, 2'h3, 1'b1, 1'b0);
    $display("test decode done");
    close_out;
  end
endmodule
